// >>> pkg/sdram_cmd_pkg.sv
package sdram_cmd_pkg;

	// Geometry
	localparam int NUM_BANKS = 4;
	localparam int BA_W      = 2;
	localparam int ADDR_W    = 12;
	localparam int AP_BIT    = 10;  // Auto precharge on column access, all banks on precharge
	localparam int TMR_W     = 5;

	// Clock and timing; clock period in ps, times in ns, counts rounded up to whole cycles
	localparam int CLK_PS     = 8000;
	localparam int T_RP_NS    = 24;
	localparam int T_RCD_NS   = 24;
	localparam int T_RFC_NS   = 80;
	localparam int T_MRD_CYC  = 2;
	localparam int BURST_LEN  = 4;
	localparam int T_RP_CYC   = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int T_RCD_CYC  = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int T_RFC_CYC  = (T_RFC_NS * 1000 + CLK_PS - 1) / CLK_PS;

	// Pin codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] PIN_NOP     = 4'h7;
	localparam logic [3:0] PIN_ACTIVE  = 4'h3;
	localparam logic [3:0] PIN_REFRESH = 4'h1;
	localparam logic [3:0] PIN_MODE    = 4'h0;
	localparam logic [3:0] PIN_READ    = 4'h5;
	localparam logic [3:0] PIN_WRITE   = 4'h4;
	localparam logic [3:0] PIN_PRECH   = 4'h2;
	localparam logic [3:0] PIN_BTERM   = 4'h6;

	// Per-bank states, Gray coded along activate, access, precharge
	typedef enum logic [2:0] {
		BANK_IDLE        = 3'h0,
		BANK_ACTIVATING  = 3'h1,
		BANK_ACTIVE      = 3'h3,
		BANK_READ        = 3'h2,
		BANK_WRITE       = 3'h6,
		BANK_READ_AP     = 3'h7,
		BANK_WRITE_AP    = 3'h5,
		BANK_PRECHARGING = 3'h4
	} bank_state_type;

	// Whole-device states
	typedef enum logic [1:0] {
		DEV_NORMAL  = 2'h0,
		DEV_REFRESH = 2'h1,
		DEV_MODE    = 2'h3,
		DEV_PREALL  = 2'h2
	} dev_state_type;

	// Commands on the controller's user side
	typedef enum logic [2:0] {
		REQ_ACTIVE  = 3'h0,
		REQ_READ    = 3'h1,
		REQ_WRITE   = 3'h3,
		REQ_PRECH   = 3'h2,
		REQ_BTERM   = 3'h6,
		REQ_REFRESH = 3'h7,
		REQ_MODE    = 3'h5
	} req_cmd_type;

endpackage

// >>> pkg/sdram_cmd_if.sv
`timescale 1ns/10ps
interface sdram_cmd_if;
	logic                              cke;
	logic                              cs_n;
	logic                              ras_n;
	logic                              cas_n;
	logic                              we_n;
	logic [sdram_cmd_pkg::BA_W-1:0]    ba;
	logic [sdram_cmd_pkg::ADDR_W-1:0]  addr;

	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
	modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// >>> hdl/sdram_bank_tracker.sv
`timescale 1ns/10ps
// Operation
// - Inhibit or NOP continues current operations
// - Decode ACTIVE, open row in bank
// - Refresh, mode load need all banks idle
// - Decode READ and WRITE, optional auto precharge
// - Decode PRECHARGE; idle bank stays idle
// - Burst terminate ends latest burst anywhere
// - Precharge truncates plain burst, starts precharging
// - New column access restarts plain burst
// - Idle after tRP, active after tRCD
// - Read/write state until burst ends
// - Precharging until tRP, then idle
// - Activating until tRCD, then active
// - Auto precharge access until tRP met
// - Busy bank receives only NOP or inhibit
// - No commands during refresh, mode, precharge-all
// - Refreshing until tRFC, then all idle
// - Mode access until tMRD, then all idle
// - Precharge all: non-idle banks precharging until tRP, idle banks stay idle
// - Precharge all only from permitted states; else violation flagged, yet DEV_PREALL still entered
// - Other banks accept ACTIVE/READ/WRITE/PRECHARGE
// - Other bank access interrupts running burst
// - Commands count only with clock enable held
module sdram_bank_tracker (
	// Clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst,
	// Command pins from the controller
	sdram_cmd_if.dev                                 pins,
	// Observed state
	output sdram_cmd_pkg::bank_state_type [3:0]      bank_state,
	output sdram_cmd_pkg::dev_state_type             dev_state,
	output logic                                     cmd_violation
);

	typedef struct packed {
		sdram_cmd_pkg::bank_state_type [3:0]         bank;
		logic [3:0][sdram_cmd_pkg::TMR_W-1:0]        tmr;
		sdram_cmd_pkg::dev_state_type                dev;
		logic [sdram_cmd_pkg::TMR_W-1:0]             dev_tmr;
		logic                                        cke_prev;
		logic [sdram_cmd_pkg::BA_W-1:0]              last_bank;
		logic                                        viol;
	} state_type;

	localparam logic [sdram_cmd_pkg::TMR_W-1:0] RP  =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_RP_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] RCD =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_RCD_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] RFC =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_RFC_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] MRD =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_MRD_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] BL  =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::BURST_LEN);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] ONE = 5'h01;

	state_type state_q;
	state_type state_d;
	logic [3:0] pin_cmd;
	logic       cmd_live;
	logic       all_idle;
	logic       ap;

	// Pin decode; controller logic shares our clock, so no synchroniser
	assign pin_cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
	assign ap      = pins.addr[sdram_cmd_pkg::AP_BIT];
	// Clock enable must be high on this and the previous edge
	assign cmd_live = pins.cke && state_q.cke_prev;

	// Next state for all banks and the whole device
	always_comb
	begin
		state_d          = state_q;
		state_d.cke_prev = pins.cke;
		state_d.viol     = 1'b0;
		all_idle         = 1'b1;

		// Timers run down; expiry moves each bank on by itself
		for (int n = 0; n < sdram_cmd_pkg::NUM_BANKS; n++)
		begin
			if (state_q.bank[n] != sdram_cmd_pkg::BANK_IDLE)
				all_idle = 1'b0;
			if (state_q.tmr[n] != '0)
				state_d.tmr[n] = state_q.tmr[n] - ONE;
			if (state_q.tmr[n] == ONE)
			begin
				case (state_q.bank[n])
					sdram_cmd_pkg::BANK_ACTIVATING:
						state_d.bank[n] = sdram_cmd_pkg::BANK_ACTIVE;
					sdram_cmd_pkg::BANK_READ,
					sdram_cmd_pkg::BANK_WRITE:
						state_d.bank[n] = sdram_cmd_pkg::BANK_ACTIVE;
					sdram_cmd_pkg::BANK_READ_AP,
					sdram_cmd_pkg::BANK_WRITE_AP,
					sdram_cmd_pkg::BANK_PRECHARGING:
						state_d.bank[n] = sdram_cmd_pkg::BANK_IDLE;
					default:
						state_d.bank[n] = state_q.bank[n];
				endcase
			end
		end

		// Whole-device operations end with their own timer
		if (state_q.dev_tmr != '0)
			state_d.dev_tmr = state_q.dev_tmr - ONE;
		if (state_q.dev_tmr == ONE)
			state_d.dev = sdram_cmd_pkg::DEV_NORMAL;

		// Inhibit and NOP fall through untouched
		if (cmd_live && !pin_cmd[3] && pin_cmd != sdram_cmd_pkg::PIN_NOP)
		begin
			if (state_q.dev != sdram_cmd_pkg::DEV_NORMAL)
				state_d.viol = 1'b1;  // Ignored while device busy
			else
			begin
				case (pin_cmd)
					sdram_cmd_pkg::PIN_ACTIVE:
					begin
						// Only the addressed bank's own state decides
						if (state_q.bank[pins.ba] == sdram_cmd_pkg::BANK_IDLE)
						begin
							state_d.bank[pins.ba] = sdram_cmd_pkg::BANK_ACTIVATING;
							state_d.tmr[pins.ba]  = RCD;
						end
						else
							state_d.viol = 1'b1;
					end
					sdram_cmd_pkg::PIN_READ,
					sdram_cmd_pkg::PIN_WRITE:
					begin
						case (state_q.bank[pins.ba])
							sdram_cmd_pkg::BANK_ACTIVE,
							sdram_cmd_pkg::BANK_READ,
							sdram_cmd_pkg::BANK_WRITE:
							begin
								// Restart of a running burst is legal
								if (pin_cmd == sdram_cmd_pkg::PIN_READ)
									state_d.bank[pins.ba] = ap ? sdram_cmd_pkg::BANK_READ_AP
										: sdram_cmd_pkg::BANK_READ;
								else
									state_d.bank[pins.ba] = ap ? sdram_cmd_pkg::BANK_WRITE_AP
										: sdram_cmd_pkg::BANK_WRITE;
								// Auto precharge counts the burst plus tRP
								state_d.tmr[pins.ba] = ap ? BL + RP : BL;
								state_d.last_bank    = pins.ba;
								// Other banks' bursts are cut short
								for (int m = 0; m < sdram_cmd_pkg::NUM_BANKS; m++)
								begin
									if (m != int'(pins.ba))
									begin
										if (state_q.bank[m] == sdram_cmd_pkg::BANK_READ
											|| state_q.bank[m] == sdram_cmd_pkg::BANK_WRITE)
										begin
											state_d.bank[m] = sdram_cmd_pkg::BANK_ACTIVE;
											state_d.tmr[m]  = '0;
										end
										else if ((state_q.bank[m] == sdram_cmd_pkg::BANK_READ_AP
											|| state_q.bank[m] == sdram_cmd_pkg::BANK_WRITE_AP)
											&& state_q.tmr[m] > RP)
											state_d.tmr[m] = RP;  // Precharge starts now
									end
								end
							end
							default:
								state_d.viol = 1'b1;
						endcase
					end
					sdram_cmd_pkg::PIN_PRECH:
					begin
						if (ap)
						begin
							// Every bank must be in a state that may precharge
							for (int m = 0; m < sdram_cmd_pkg::NUM_BANKS; m++)
							begin
								if (state_q.bank[m] == sdram_cmd_pkg::BANK_ACTIVATING
									|| state_q.bank[m] == sdram_cmd_pkg::BANK_READ_AP
									|| state_q.bank[m] == sdram_cmd_pkg::BANK_WRITE_AP)
									state_d.viol = 1'b1;
								else if (state_q.bank[m] != sdram_cmd_pkg::BANK_IDLE)
								begin
									state_d.bank[m] = sdram_cmd_pkg::BANK_PRECHARGING;
									state_d.tmr[m]  = RP;
								end
							end
							state_d.dev     = sdram_cmd_pkg::DEV_PREALL;
							state_d.dev_tmr = RP;
						end
						else
						begin
							case (state_q.bank[pins.ba])
								sdram_cmd_pkg::BANK_IDLE:
									state_d.bank[pins.ba] = sdram_cmd_pkg::BANK_IDLE;
								sdram_cmd_pkg::BANK_ACTIVE,
								sdram_cmd_pkg::BANK_READ,
								sdram_cmd_pkg::BANK_WRITE:
								begin
									// Truncates any plain burst
									state_d.bank[pins.ba] = sdram_cmd_pkg::BANK_PRECHARGING;
									state_d.tmr[pins.ba]  = RP;
								end
								default:
									state_d.viol = 1'b1;
							endcase
						end
					end
					sdram_cmd_pkg::PIN_BTERM:
					begin
						// Acts on the latest burst whatever bank it is
						case (state_q.bank[state_q.last_bank])
							sdram_cmd_pkg::BANK_READ,
							sdram_cmd_pkg::BANK_WRITE:
							begin
								state_d.bank[state_q.last_bank] = sdram_cmd_pkg::BANK_ACTIVE;
								state_d.tmr[state_q.last_bank]  = '0;
							end
							sdram_cmd_pkg::BANK_READ_AP,
							sdram_cmd_pkg::BANK_WRITE_AP:
								if (state_q.tmr[state_q.last_bank] > RP)
									state_d.tmr[state_q.last_bank] = RP;
							default:
								state_d.viol = 1'b1;
						endcase
					end
					sdram_cmd_pkg::PIN_REFRESH,
					sdram_cmd_pkg::PIN_MODE:
					begin
						if (!all_idle)
							state_d.viol = 1'b1;
						else if (pin_cmd == sdram_cmd_pkg::PIN_REFRESH)
						begin
							state_d.dev     = sdram_cmd_pkg::DEV_REFRESH;
							state_d.dev_tmr = RFC;
						end
						else
						begin
							state_d.dev     = sdram_cmd_pkg::DEV_MODE;
							state_d.dev_tmr = MRD;
						end
					end
					default:
						state_d.viol = 1'b0;
				endcase
			end
		end
	end

	// Single state register; every output is a field of it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign bank_state    = state_q.bank;
	assign dev_state     = state_q.dev;
	assign cmd_violation = state_q.viol;

endmodule

// >>> hdl/sdram_cmd_issuer.sv
`timescale 1ns/10ps
module sdram_cmd_issuer (
	// Clock and reset
	input  wire logic                                    clk,
	input  wire logic                                    rst,
	// User request
	input  wire logic                                    req_valid,
	input  sdram_cmd_pkg::req_cmd_type                   req_cmd,
	input  wire logic [sdram_cmd_pkg::BA_W-1:0]          req_bank,
	input  wire logic [sdram_cmd_pkg::ADDR_W-1:0]        req_addr,
	output logic                                         req_taken,
	output logic [3:0]                                   bank_free,
	// Command pins to the memory
	sdram_cmd_if.ctrl                                    pins
);

	typedef struct packed {
		logic [3:0][sdram_cmd_pkg::TMR_W-1:0]        lock;
		logic [sdram_cmd_pkg::TMR_W-1:0]             dev_lock;
		logic [3:0]                                  open;
		logic [3:0]                                  pin_cmd;
		logic [sdram_cmd_pkg::BA_W-1:0]              ba;
		logic [sdram_cmd_pkg::ADDR_W-1:0]            addr;
		logic                                        cke;
		logic                                        taken;
		logic [3:0]                                  free;
	} state_type;

	localparam logic [sdram_cmd_pkg::TMR_W-1:0] RP  =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_RP_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] RCD =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_RCD_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] RFC =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_RFC_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] MRD =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::T_MRD_CYC);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] BL  =
		sdram_cmd_pkg::TMR_W'(sdram_cmd_pkg::BURST_LEN);
	localparam logic [sdram_cmd_pkg::TMR_W-1:0] ONE = 5'h01;

	state_type state_q;
	state_type state_d;
	logic      ok;
	logic      ap;

	assign ap = req_addr[sdram_cmd_pkg::AP_BIT];

	// Locks are conservative: an interrupted auto precharge still waits the full count
	always_comb
	begin
		state_d         = state_q;
		state_d.cke     = 1'b1;  // Held high one edge before the first command
		state_d.pin_cmd = sdram_cmd_pkg::PIN_NOP;  // Idle edges carry NOP
		state_d.taken   = 1'b0;
		ok              = 1'b0;
		for (int n = 0; n < sdram_cmd_pkg::NUM_BANKS; n++)
			if (state_q.lock[n] != '0)
				state_d.lock[n] = state_q.lock[n] - ONE;
		if (state_q.dev_lock != '0)
			state_d.dev_lock = state_q.dev_lock - ONE;

		// Nothing but NOP while the device is busy
		if (req_valid && state_q.cke && state_q.dev_lock == '0)
		begin
			case (req_cmd)
				sdram_cmd_pkg::REQ_REFRESH,
				sdram_cmd_pkg::REQ_MODE:
					ok = state_q.lock == '0 && state_q.open == '0;
				sdram_cmd_pkg::REQ_PRECH:
					ok = ap ? state_q.lock == '0 : state_q.lock[req_bank] == '0;
				sdram_cmd_pkg::REQ_ACTIVE:
					ok = state_q.lock[req_bank] == '0 && !state_q.open[req_bank];
				sdram_cmd_pkg::REQ_BTERM:
					ok = 1'b1;
				default:
					ok = state_q.lock[req_bank] == '0 && state_q.open[req_bank];
			endcase
		end

		// Busy banks get nothing; others proceed freely
		if (ok)
		begin
			state_d.taken = 1'b1;
			state_d.ba    = req_bank;
			state_d.addr  = req_addr;
			case (req_cmd)
				sdram_cmd_pkg::REQ_ACTIVE:
				begin
					state_d.pin_cmd        = sdram_cmd_pkg::PIN_ACTIVE;
					state_d.lock[req_bank] = RCD;
					state_d.open[req_bank] = 1'b1;
				end
				sdram_cmd_pkg::REQ_READ,
				sdram_cmd_pkg::REQ_WRITE:
				begin
					state_d.pin_cmd = (req_cmd == sdram_cmd_pkg::REQ_READ)
						? sdram_cmd_pkg::PIN_READ : sdram_cmd_pkg::PIN_WRITE;
					if (ap)
					begin
						state_d.lock[req_bank] = BL + RP;
						state_d.open[req_bank] = 1'b0;
					end
				end
				sdram_cmd_pkg::REQ_PRECH:
				begin
					state_d.pin_cmd = sdram_cmd_pkg::PIN_PRECH;
					if (ap)
					begin
						state_d.dev_lock = RP;
						state_d.open     = '0;
					end
					else
					begin
						state_d.lock[req_bank] = RP;
						state_d.open[req_bank] = 1'b0;
					end
				end
				sdram_cmd_pkg::REQ_BTERM:
					state_d.pin_cmd = sdram_cmd_pkg::PIN_BTERM;
				sdram_cmd_pkg::REQ_REFRESH:
				begin
					state_d.pin_cmd  = sdram_cmd_pkg::PIN_REFRESH;
					state_d.dev_lock = RFC;
				end
				default:
				begin
					state_d.pin_cmd  = sdram_cmd_pkg::PIN_MODE;
					state_d.dev_lock = MRD;
				end
			endcase
		end

		for (int n = 0; n < sdram_cmd_pkg::NUM_BANKS; n++)
			state_d.free[n] = state_d.lock[n] == '0 && state_d.dev_lock == '0;
	end

	// Single state register; pins come straight from it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q         <= '0;
			state_q.pin_cmd <= sdram_cmd_pkg::PIN_NOP;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign pins.cke   = state_q.cke;
	assign pins.cs_n  = state_q.pin_cmd[3];
	assign pins.ras_n = state_q.pin_cmd[2];
	assign pins.cas_n = state_q.pin_cmd[1];
	assign pins.we_n  = state_q.pin_cmd[0];
	assign pins.ba    = state_q.ba;
	assign pins.addr  = state_q.addr;
	assign req_taken  = state_q.taken;
	assign bank_free  = state_q.free;

endmodule

// >>> sim/sdram_cmd_props.sv
`timescale 1ns/10ps
module sdram_cmd_props (
	// Clock and reset
	input wire logic                           clk,
	input wire logic                           rst,
	// Command pins
	input wire logic                           cke,
	input wire logic                           cs_n,
	input wire logic                           ras_n,
	input wire logic                           cas_n,
	input wire logic                           we_n,
	input wire logic [1:0]                     ba,
	input wire logic [11:0]                    addr,
	// Tracker state
	input sdram_cmd_pkg::bank_state_type [3:0] bank_state,
	input sdram_cmd_pkg::dev_state_type        dev_state,
	input wire logic                           cmd_violation
);
	logic       cke_q;
	logic [3:0] cmd;
	logic       live;
	logic       quiet;

	// Clock enable one edge back; a command counts only when it was held
	always_ff @(posedge clk)
	begin
		cke_q <= rst ? 1'b0 : cke;
	end

	// Decoded pin view
	assign cmd   = {cs_n, ras_n, cas_n, we_n};
	assign live  = cke && cke_q && !cs_n;
	assign quiet = cs_n || cmd == sdram_cmd_pkg::PIN_NOP;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_quiet_no_cke: assert property (!cke |-> quiet)
		else $error("command driven while clock enable low");
	a_active_opens: assert property (live && cmd == sdram_cmd_pkg::PIN_ACTIVE
		&& bank_state[ba] == sdram_cmd_pkg::BANK_IDLE && dev_state == sdram_cmd_pkg::DEV_NORMAL
		|=> bank_state[$past(ba)] == sdram_cmd_pkg::BANK_ACTIVATING)
		else $error("activate did not open the bank");
	a_activate_time: assert property ($changed(bank_state[0])
		&& bank_state[0] == sdram_cmd_pkg::BANK_ACTIVATING
		|-> ##2 bank_state[0] == sdram_cmd_pkg::BANK_ACTIVATING
		##1 bank_state[0] == sdram_cmd_pkg::BANK_ACTIVE)
		else $error("row activation length wrong");
	a_prech_time: assert property ($changed(bank_state[0])
		&& bank_state[0] == sdram_cmd_pkg::BANK_PRECHARGING
		|-> ##2 bank_state[0] == sdram_cmd_pkg::BANK_PRECHARGING
		##1 bank_state[0] == sdram_cmd_pkg::BANK_IDLE)
		else $error("precharge length wrong");
	a_read_starts: assert property (live && cmd == sdram_cmd_pkg::PIN_READ
		&& !addr[sdram_cmd_pkg::AP_BIT]
		&& bank_state[ba] == sdram_cmd_pkg::BANK_ACTIVE && dev_state == sdram_cmd_pkg::DEV_NORMAL
		|=> bank_state[$past(ba)] == sdram_cmd_pkg::BANK_READ)
		else $error("read did not start a burst");
	a_prech_noop: assert property (live && cmd == sdram_cmd_pkg::PIN_PRECH
		&& !addr[sdram_cmd_pkg::AP_BIT]
		&& bank_state[ba] == sdram_cmd_pkg::BANK_IDLE && dev_state == sdram_cmd_pkg::DEV_NORMAL
		|=> bank_state[$past(ba)] == sdram_cmd_pkg::BANK_IDLE && !cmd_violation)
		else $error("precharge of idle bank changed it");
	a_refresh_time: assert property ($changed(dev_state)
		&& dev_state == sdram_cmd_pkg::DEV_REFRESH
		|-> ##9 dev_state == sdram_cmd_pkg::DEV_REFRESH
		##1 (dev_state == sdram_cmd_pkg::DEV_NORMAL && bank_state == '0))
		else $error("refresh length wrong");
	a_mode_time: assert property ($changed(dev_state)
		&& dev_state == sdram_cmd_pkg::DEV_MODE
		|-> ##1 dev_state == sdram_cmd_pkg::DEV_MODE
		##1 dev_state == sdram_cmd_pkg::DEV_NORMAL)
		else $error("mode access length wrong");
	a_quiet_busy: assert property (dev_state != sdram_cmd_pkg::DEV_NORMAL |-> quiet)
		else $error("command sent during device operation");
	a_legal_only: assert property (!cmd_violation)
		else $error("issuer sent a refused command");
endmodule

// >>> sim/sdram_bank_command_state_logic_tb.sv
`timescale 1ns/10ps
module sdram_bank_command_state_logic_tb;
	// Clock, reset and user side
	logic                                clk;
	logic                                rst;
	logic                                req_valid;
	sdram_cmd_pkg::req_cmd_type          req_cmd;
	logic [1:0]                          req_bank;
	logic [11:0]                         req_addr;
	logic                                req_taken;
	logic [3:0]                          bank_free;
	// Tracker outputs, issuer pair and directly driven pair
	sdram_cmd_pkg::bank_state_type [3:0] bank_state;
	sdram_cmd_pkg::bank_state_type [3:0] raw_state;
	sdram_cmd_pkg::dev_state_type        dev_state;
	sdram_cmd_pkg::dev_state_type        raw_dev;
	logic                                violation;
	logic                                raw_violation;
	int                                  n_fail;
	int                                  tests_run;
	int                                  cycles;

	sdram_cmd_if pins ();
	sdram_cmd_if raw ();

	sdram_cmd_issuer i_sdram_cmd_issuer (
		.clk       (clk),
		.rst       (rst),
		.req_valid (req_valid),
		.req_cmd   (req_cmd),
		.req_bank  (req_bank),
		.req_addr  (req_addr),
		.req_taken (req_taken),
		.bank_free (bank_free),
		.pins      (pins)
	);
	sdram_bank_tracker i_sdram_bank_tracker (
		.clk           (clk),
		.rst           (rst),
		.pins          (pins),
		.bank_state    (bank_state),
		.dev_state     (dev_state),
		.cmd_violation (violation)
	);
	// Second tracker takes deliberately broken command streams
	sdram_bank_tracker i_sdram_bank_tracker_raw (
		.clk           (clk),
		.rst           (rst),
		.pins          (raw),
		.bank_state    (raw_state),
		.dev_state     (raw_dev),
		.cmd_violation (raw_violation)
	);
	sdram_cmd_props i_sdram_cmd_props (
		.clk           (clk),
		.rst           (rst),
		.cke           (pins.cke),
		.cs_n          (pins.cs_n),
		.ras_n         (pins.ras_n),
		.cas_n         (pins.cas_n),
		.we_n          (pins.we_n),
		.ba            (pins.ba),
		.addr          (pins.addr),
		.bank_state    (bank_state),
		.dev_state     (dev_state),
		.cmd_violation (violation)
	);

	// Clock at 125 MHz
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Hang guard; the whole run needs about 130 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Single compare for every small code, four-state exact
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Settle just after an edge so registered outputs have landed
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Raw pair checks
	task automatic rb(input int b, input logic [3:0] e);
		chk("raw bank state", e, raw_state[b]);
	endtask
	task automatic rv(input logic e);
		chk("raw violation", {3'h0, e}, {3'h0, raw_violation});
	endtask

	// User request, raised only when every lock is clear so it is taken at once
	task automatic issue(input sdram_cmd_pkg::req_cmd_type c, input logic [3:0] pin,
		input logic [1:0] b, input logic [11:0] a);
		int n;
		for (n = 0; n < 40 && bank_free !== 4'hF; n++)
			step(1);
		@(posedge clk);
		req_valid <= 1'b1;
		req_cmd   <= c;
		req_bank  <= b;
		req_addr  <= a;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		chk("req_taken", 4'h1, {3'h0, req_taken});
		chk("pin command", pin, {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
		chk("pin bank", {2'h0, b}, {2'h0, pins.ba});
	endtask

	// One command on the raw pins, NOP after; returns with its effect visible
	task automatic drv(input logic [3:0] c, input logic [1:0] b, input logic ap);
		@(posedge clk);
		{raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n} <= c;
		raw.ba   <= b;
		raw.addr <= {1'b0, ap, 10'h000};
		@(posedge clk);
		{raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n} <= sdram_cmd_pkg::PIN_NOP;
		raw.ba   <= ~b;
		raw.addr <= 12'hBFF;
		#1;
	endtask

	// Issuer pair: open, read, close, idle close, refresh, mode load
	task automatic t_issuer();
		issue(sdram_cmd_pkg::REQ_ACTIVE, sdram_cmd_pkg::PIN_ACTIVE, 2'h0, 12'h000);
		chk("bank free", 4'hE, bank_free);
		step(1);
		chk("bank 0", sdram_cmd_pkg::BANK_ACTIVATING, bank_state[0]);
		chk("bank 1", sdram_cmd_pkg::BANK_IDLE, bank_state[1]);
		step(3);
		chk("bank 0", sdram_cmd_pkg::BANK_ACTIVE, bank_state[0]);
		issue(sdram_cmd_pkg::REQ_READ, sdram_cmd_pkg::PIN_READ, 2'h0, 12'h000);
		step(1);
		chk("bank 0", sdram_cmd_pkg::BANK_READ, bank_state[0]);
		issue(sdram_cmd_pkg::REQ_BTERM, sdram_cmd_pkg::PIN_BTERM, 2'h0, 12'h000);
		step(1);
		chk("bank 0", sdram_cmd_pkg::BANK_ACTIVE, bank_state[0]);
		issue(sdram_cmd_pkg::REQ_PRECH, sdram_cmd_pkg::PIN_PRECH, 2'h0, 12'h000);
		step(3);
		chk("bank 0", sdram_cmd_pkg::BANK_PRECHARGING, bank_state[0]);
		step(1);
		chk("bank 0", sdram_cmd_pkg::BANK_IDLE, bank_state[0]);
		issue(sdram_cmd_pkg::REQ_PRECH, sdram_cmd_pkg::PIN_PRECH, 2'h3, 12'h000);
		step(1);
		chk("bank 3", sdram_cmd_pkg::BANK_IDLE, bank_state[3]);
		issue(sdram_cmd_pkg::REQ_REFRESH, sdram_cmd_pkg::PIN_REFRESH, 2'h0, 12'h000);
		step(1);
		chk("device", sdram_cmd_pkg::DEV_REFRESH, dev_state);
		issue(sdram_cmd_pkg::REQ_MODE, sdram_cmd_pkg::PIN_MODE, 2'h0, 12'h000);
		step(1);
		chk("device", sdram_cmd_pkg::DEV_MODE, dev_state);
	endtask

	// Inhibit and a dropped clock enable leave everything alone
	task automatic t_raw_ignore();
		@(posedge clk);
		raw.cke <= 1'b0;
		drv(sdram_cmd_pkg::PIN_ACTIVE, 2'h0, 1'b0);
		rb(0, sdram_cmd_pkg::BANK_IDLE);
		@(posedge clk);
		raw.cke <= 1'b1;
		step(2);
		drv(4'hB, 2'h0, 1'b0);
		rb(0, sdram_cmd_pkg::BANK_IDLE);
		drv(4'h8, 2'h0, 1'b0);
		rv(1'b0);
		chk("raw device", sdram_cmd_pkg::DEV_NORMAL, raw_dev);
	endtask

	// One bank through refusal, restart, terminate and truncation
	task automatic t_raw_bank();
		drv(sdram_cmd_pkg::PIN_ACTIVE, 2'h0, 1'b0);
		rb(0, sdram_cmd_pkg::BANK_ACTIVATING);
		drv(sdram_cmd_pkg::PIN_ACTIVE, 2'h0, 1'b0);
		rv(1'b1);
		rb(0, sdram_cmd_pkg::BANK_ACTIVATING);
		step(1);
		rb(0, sdram_cmd_pkg::BANK_ACTIVE);
		drv(sdram_cmd_pkg::PIN_READ, 2'h0, 1'b0);
		step(1);
		drv(sdram_cmd_pkg::PIN_READ, 2'h0, 1'b0);
		step(1);
		rb(0, sdram_cmd_pkg::BANK_READ);
		drv(sdram_cmd_pkg::PIN_BTERM, 2'h2, 1'b0);
		rb(0, sdram_cmd_pkg::BANK_ACTIVE);
		drv(sdram_cmd_pkg::PIN_WRITE, 2'h0, 1'b0);
		rb(0, sdram_cmd_pkg::BANK_WRITE);
		drv(sdram_cmd_pkg::PIN_PRECH, 2'h0, 1'b0);
		rb(0, sdram_cmd_pkg::BANK_PRECHARGING);
		step(3);
		rb(0, sdram_cmd_pkg::BANK_IDLE);
	endtask

	// Two banks: idle close, overlap, interruption, auto precharge
	task automatic t_raw_other();
		drv(sdram_cmd_pkg::PIN_PRECH, 2'h1, 1'b0);
		rb(1, sdram_cmd_pkg::BANK_IDLE);
		rv(1'b0);
		drv(sdram_cmd_pkg::PIN_ACTIVE, 2'h0, 1'b0);
		drv(sdram_cmd_pkg::PIN_ACTIVE, 2'h1, 1'b0);
		rv(1'b0);
		step(3);
		rb(1, sdram_cmd_pkg::BANK_ACTIVE);
		drv(sdram_cmd_pkg::PIN_READ, 2'h0, 1'b0);
		drv(sdram_cmd_pkg::PIN_WRITE, 2'h1, 1'b1);
		rb(0, sdram_cmd_pkg::BANK_ACTIVE);
		rb(1, sdram_cmd_pkg::BANK_WRITE_AP);
		step(6);
		rb(1, sdram_cmd_pkg::BANK_WRITE_AP);
		step(1);
		rb(1, sdram_cmd_pkg::BANK_IDLE);
	endtask

	// Whole-device operations and commands refused during them
	task automatic t_raw_device();
		drv(sdram_cmd_pkg::PIN_REFRESH, 2'h0, 1'b0);
		rv(1'b1);
		drv(sdram_cmd_pkg::PIN_PRECH, 2'h0, 1'b1);
		chk("raw device", sdram_cmd_pkg::DEV_PREALL, raw_dev);
		rb(0, sdram_cmd_pkg::BANK_PRECHARGING);
		step(3);
		chk("raw device", sdram_cmd_pkg::DEV_NORMAL, raw_dev);
		rb(0, sdram_cmd_pkg::BANK_IDLE);
		drv(sdram_cmd_pkg::PIN_REFRESH, 2'h0, 1'b0);
		drv(sdram_cmd_pkg::PIN_ACTIVE, 2'h2, 1'b0);
		rv(1'b1);
		step(7);
		chk("raw device", sdram_cmd_pkg::DEV_REFRESH, raw_dev);
		step(1);
		chk("raw device", sdram_cmd_pkg::DEV_NORMAL, raw_dev);
		drv(sdram_cmd_pkg::PIN_MODE, 2'h0, 1'b0);
		step(1);
		chk("raw device", sdram_cmd_pkg::DEV_MODE, raw_dev);
		step(1);
		chk("raw device", sdram_cmd_pkg::DEV_NORMAL, raw_dev);
	endtask

	// Main sequence
	initial
	begin
		rst       = 1'b1;
		req_valid = 1'b0;
		req_cmd   = sdram_cmd_pkg::REQ_ACTIVE;
		req_bank  = 2'h0;
		req_addr  = 12'h000;
		raw.cke   = 1'b0;
		{raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n} = 4'hF;
		raw.ba    = 2'h0;
		raw.addr  = 12'h000;
		n_fail    = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		rst     <= 1'b0;
		raw.cke <= 1'b1;
		step(3);
		t_issuer();
		t_raw_ignore();
		t_raw_bank();
		t_raw_other();
		t_raw_device();
		step(12);
		end_sim();
	end
endmodule
